/* File: design/frsc_top.sv */
/*
 Flash rewrite sequencer with security gating and boot swap.
 Assumes an APB master in the same clock domain; array modelled as a word memory.
*/
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module frsc_top
    import frsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device configuration and interrupt request
    input wire logic cap_256k,
    input wire logic irq_req,
    // Instruction fetch port and interrupt acknowledge
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    output logic [31:0] fetch_data,
    output logic fetch_valid,
    output logic fetch_blocked,
    output logic irq_ack
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Security word lives outside the reset domain in a real part; here it
    // starts at its shipment value and keeps its current value across reset as the nonvolatile model.
    logic [31:0] mem [0:FRSC_MAX_BLKS*FRSC_BLK_WORDS-1];
    logic [15:0] sec = FRSC_SEC_RST;
    logic [1:0] ctrl;
    frsc_op_t op;
    frsc_state_t state;
    frsc_status_t stat;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [15:0] last;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic busy = (state != FRSC_IDLE);
    wire logic pgm_mode = ctrl[FRSC_CTRL_PGM];
    wire logic [7:0] nblks = cap_256k ? FRSC_BLKS_256K : FRSC_BLKS_128K;
    wire logic [7:0] cmd_blk = pwdata[15:8];
    wire logic [8:0] cmd_word = pwdata[24:16];
    wire frsc_op_t cmd_op = frsc_op_t'(pwdata[2:0]);
    wire logic [7:0] boot_last = sec[FRSC_SEC_LAST_LO +: 8];

    // Boot swap only touches blocks 0..7, other blocks map straight through
    function automatic logic [15:0] frsc_map(input logic [15:0] a, input logic swap);
        logic [7:0] b;
        b = a[15:8] >> 1;
        if (swap && b <= FRSC_BOOT0_LAST) begin
            return a + {FRSC_SWAP_OFS, 8'h00} * 16'h0002;
        end
        if (swap && b >= FRSC_SWAP_OFS && b < 8'h08) begin
            return a - {FRSC_SWAP_OFS, 8'h00} * 16'h0002;
        end
        return a;
    endfunction : frsc_map

    // Security gate evaluated on the flags as sampled at command time
    wire logic boot_hit = sec[FRSC_SEC_BOOT] && (cmd_blk <= boot_last);
    wire logic blk_range = (cmd_blk < nblks);
    wire logic erase_bad = sec[FRSC_SEC_BLK_ERASE] || sec[FRSC_SEC_CHIP_ERASE]
        || sec[FRSC_SEC_PROGRAM];
    logic cmd_ok;
    always_comb begin
        case (cmd_op)
            FRSC_OP_BLK_ERASE: cmd_ok = blk_range && !boot_hit
                && !(pgm_mode && erase_bad);
            FRSC_OP_CHIP_ERASE: cmd_ok = pgm_mode && !sec[FRSC_SEC_CHIP_ERASE]
                && !sec[FRSC_SEC_BOOT];
            FRSC_OP_WRITE: cmd_ok = blk_range && !boot_hit
                && !(pgm_mode && sec[FRSC_SEC_PROGRAM]);
            FRSC_OP_VERIFY: cmd_ok = pgm_mode && blk_range;
            FRSC_OP_BLANK: cmd_ok = blk_range;
            FRSC_OP_SECURE: cmd_ok = pgm_mode
                || ((wdata[15:0] & sec) == sec);
            FRSC_OP_READ: cmd_ok = blk_range
                && !(pgm_mode && sec[FRSC_SEC_READ]);
            default: cmd_ok = 1'b0;
        endcase
    end

    wire logic start = wr && (paddr == FRSC_CMD_OFS) && !busy;
    wire logic [15:0] cmd_addr = {cmd_blk, 8'h00} * 16'h0002 + {7'h00, cmd_word};
    wire logic [15:0] phys = addr;
    // Single-word ops run on the given word; block ops sweep the whole block
    wire logic word_op = (cmd_op == FRSC_OP_WRITE) || (cmd_op == FRSC_OP_READ)
        || (cmd_op == FRSC_OP_VERIFY) || (cmd_op == FRSC_OP_SECURE);

    // ------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= 2'h0;
            wdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (wr && paddr == FRSC_CTRL_OFS && !busy) begin
                ctrl <= pwdata[1:0];
            end
            if (wr && paddr == FRSC_WDATA_OFS) begin
                wdata <= pwdata;
            end
            if (psel && !penable) begin
                case (paddr)
                    FRSC_CTRL_OFS: prdata <= {30'h0, ctrl};
                    FRSC_WDATA_OFS: prdata <= wdata;
                    FRSC_STAT_OFS: prdata <= {28'h0, stat.mismatch, stat.rejected, stat.done, stat.busy};
                    FRSC_SEC_OFS: prdata <= {16'h0, sec};
                    FRSC_RDATA_OFS: prdata <= rdata;
                    FRSC_CMD_OFS: prdata <= {29'h0, op};
                    default: begin
                        prdata <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= FRSC_IDLE;
            op <= FRSC_OP_NONE;
            stat <= '0;
            addr <= 16'h0000;
            last <= 16'h0000;
            rdata <= 32'h00000000;
        end else begin
            case (state)
                FRSC_IDLE: begin
                    if (start) begin
                        stat.done <= 1'b0;
                        stat.mismatch <= 1'b0;
                        stat.rejected <= !cmd_ok;
                        if (cmd_ok) begin
                            op <= cmd_op;
                            stat.busy <= 1'b1;
                            state <= FRSC_RUN;
                            addr <= (cmd_op == FRSC_OP_CHIP_ERASE) ? 16'h0000
                                : (word_op ? cmd_addr : {cmd_blk[6:0], 9'h000});
                            last <= (cmd_op == FRSC_OP_CHIP_ERASE) ? {nblks, 8'h00} * 16'h0002 - 16'h0001
                                : (word_op ? cmd_addr : {cmd_blk[6:0], 9'h1FF});
                        end else begin
                            stat.done <= 1'b1;
                        end
                    end
                end
                FRSC_RUN: begin
                    case (op)
                        FRSC_OP_BLK_ERASE, FRSC_OP_CHIP_ERASE: mem[phys] <= FRSC_ERASED;
                        FRSC_OP_WRITE: mem[phys] <= mem[phys] & wdata;
                        FRSC_OP_BLANK: if (mem[phys] != FRSC_ERASED) stat.mismatch <= 1'b1;
                        FRSC_OP_VERIFY: if (mem[phys] != wdata) stat.mismatch <= 1'b1;
                        FRSC_OP_READ: rdata <= mem[frsc_map(addr, ctrl[FRSC_CTRL_SWAP])];
                        FRSC_OP_SECURE: sec <= wdata[15:0];
                        default: stat.mismatch <= 1'b0;
                    endcase
                    if (addr == last) begin
                        state <= FRSC_CHECK;
                    end else begin
                        addr <= addr + 16'h0001;
                    end
                end
                FRSC_CHECK: begin
                    if (op == FRSC_OP_WRITE && mem[phys] != (mem[phys] & wdata)) begin
                        stat.mismatch <= 1'b1;
                    end
                    if (op == FRSC_OP_WRITE && (mem[phys] | ~wdata) != ~32'h0) begin
                        stat.mismatch <= 1'b1;
                    end
                    if (op == FRSC_OP_CHIP_ERASE) begin
                        // Boot protection is kept, the three clearable prohibits drop
                        sec[FRSC_SEC_BLK_ERASE] <= 1'b0;
                        sec[FRSC_SEC_PROGRAM] <= 1'b0;
                        sec[FRSC_SEC_READ] <= 1'b0;
                    end
                    state <= FRSC_DONE;
                end
                FRSC_DONE: begin
                    stat.busy <= 1'b0;
                    stat.done <= 1'b1;
                    state <= FRSC_IDLE;
                end
                default: state <= FRSC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Fetch path and interrupt pass-through
    // ------------------------------------------------------------
    wire logic self_busy = busy && !pgm_mode;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fetch_data <= 32'h00000000;
            fetch_valid <= 1'b0;
            fetch_blocked <= 1'b0;
            irq_ack <= 1'b0;
        end else begin
            fetch_valid <= fetch_req && !self_busy;
            fetch_blocked <= fetch_req && self_busy;
            fetch_data <= self_busy ? 32'h00000000
                : mem[frsc_map(fetch_addr, ctrl[FRSC_CTRL_SWAP])];
            irq_ack <= irq_req;
        end
    end

endmodule : frsc_top
`default_nettype wire

/* File: pkg/frsc_pkg.sv */
/*
 Constants, register map and command codes for the flash rewrite sequencer.
 Assumes an APB master with 32-bit data and word aligned registers.
*/
package frsc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] FRSC_CTRL_OFS = 8'h00;
    localparam logic [7:0] FRSC_CMD_OFS = 8'h04;
    localparam logic [7:0] FRSC_WDATA_OFS = 8'h08;
    localparam logic [7:0] FRSC_STAT_OFS = 8'h0C;
    localparam logic [7:0] FRSC_SEC_OFS = 8'h10;
    localparam logic [7:0] FRSC_RDATA_OFS = 8'h14;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int FRSC_BLK_WORDS = 512;
    localparam int FRSC_MAX_BLKS = 128;
    localparam logic [7:0] FRSC_BLKS_256K = 8'h80;
    localparam logic [7:0] FRSC_BLKS_128K = 8'h40;
    localparam logic [7:0] FRSC_BOOT0_LAST = 8'h03;
    localparam logic [7:0] FRSC_SWAP_OFS = 8'h04;
    localparam logic [31:0] FRSC_ERASED = 32'hFFFFFFFF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FRSC_CTRL_SWAP = 0;
    localparam int FRSC_CTRL_PGM = 1;
    localparam int FRSC_SEC_BLK_ERASE = 0;
    localparam int FRSC_SEC_CHIP_ERASE = 1;
    localparam int FRSC_SEC_PROGRAM = 2;
    localparam int FRSC_SEC_READ = 3;
    localparam int FRSC_SEC_BOOT = 4;
    localparam int FRSC_SEC_LAST_LO = 8;

    // Security reset value: erase and program prohibits set at shipment
    localparam logic [15:0] FRSC_SEC_RST = 16'h0007;

    // Processing steps per word; at 20 ns one step per clock
    localparam int FRSC_STEP_NS = 20;
    localparam int FRSC_CLK_NS = 20;
    localparam int FRSC_STEP_CYC = (FRSC_STEP_NS + FRSC_CLK_NS - 1) / FRSC_CLK_NS;

    typedef enum logic [2:0] {
        FRSC_OP_NONE = 3'h0,
        FRSC_OP_BLK_ERASE = 3'h1,
        FRSC_OP_CHIP_ERASE = 3'h2,
        FRSC_OP_WRITE = 3'h3,
        FRSC_OP_VERIFY = 3'h4,
        FRSC_OP_BLANK = 3'h5,
        FRSC_OP_SECURE = 3'h6,
        FRSC_OP_READ = 3'h7
    } frsc_op_t;

    typedef enum logic [1:0] {
        FRSC_IDLE = 2'b00,
        FRSC_RUN = 2'b01,
        FRSC_CHECK = 2'b11,
        FRSC_DONE = 2'b10
    } frsc_state_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic rejected;
        logic mismatch;
    } frsc_status_t;

endpackage : frsc_pkg

/* File: testbench/frsc_prog_model.sv */
/* APB master model standing in for the software side.
   Assumes tasks are called right after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module frsc_prog_model (
    // Clock
    input wire logic clk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rd_data;
    logic rd_err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Idle cycle at the end so the next call never re-drives psel at the same edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (!pready) begin
            @(posedge clk);
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
        @(posedge clk);
    endtask : xfer
endmodule : frsc_prog_model
`default_nettype wire

/* File: testbench/frsc_top_asserts.sv */
/* Port-level checker for the flash sequencer top.
   Assumes one clock domain and an async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module frsc_top_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Side ports
    input wire logic irq_req,
    input wire logic irq_ack,
    input wire logic fetch_req,
    input wire logic fetch_valid,
    input wire logic fetch_blocked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_access)
        else $error("no ready one cycle after setup");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_error_unmapped: assert property (pready && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_no_error: assert property (pready && paddr <= 8'h14 |-> !pslverr)
        else $error("error on mapped access");
    a_error_needs_ready: assert property (pslverr |-> pready)
        else $error("error outside access cycle");
    a_irq_echo: assert property (1'b1 |=> irq_ack == $past(irq_req))
        else $error("interrupt acknowledge lost");
    a_fetch_served: assert property (fetch_req |=> fetch_valid != fetch_blocked)
        else $error("fetch not answered next cycle");
    a_fetch_refused: assert property (fetch_blocked |-> !fetch_valid)
        else $error("fetch served while programming");
    a_fetch_no_spurious: assert property (!fetch_req |=> !fetch_valid && !fetch_blocked)
        else $error("fetch answer without request");
endmodule : frsc_top_asserts
bind frsc_top frsc_top_asserts frsc_top_asserts_i (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
    .irq_ack(irq_ack), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
    .fetch_blocked(fetch_blocked));
`default_nettype wire

/* File: testbench/frsc_top_test.sv */
/* Self-checking bench for the flash sequencer top.
   Assumes the APB model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module frsc_top_test
    import frsc_pkg::*;
;
    logic clk, nrst, cap_256k, irq_req, fetch_req;
    logic psel, penable, pwrite, pready, pslverr, fetch_valid, fetch_blocked, irq_ack;
    logic [7:0] paddr;
    logic [15:0] fetch_addr;
    logic [31:0] pwdata, prdata, fetch_data, v;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    frsc_top frsc_top_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cap_256k(cap_256k), .irq_req(irq_req), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_data(fetch_data), .fetch_valid(fetch_valid),
        .fetch_blocked(fetch_blocked), .irq_ack(irq_ack));
    frsc_prog_model frsc_prog_model_i (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic finish_test();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // A chip erase of 64 blocks dominates the run time
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        frsc_prog_model_i.xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        frsc_prog_model_i.xfer(1'b0, a, 32'h0);
        d = frsc_prog_model_i.rd_data;
    endtask : rd
    task automatic waitdone(input logic [3:0] e);
        logic [31:0] s;
        s = 32'h0;
        while (!s[1] && cycles < 60000) begin
            rd(FRSC_STAT_OFS, s);
        end
        chk({28'h0, s[3:0]}, {28'h0, e});
    endtask : waitdone
    task automatic cmdc(input frsc_op_t op, input logic [7:0] b, input logic [8:0] w,
        input logic [31:0] d, input logic [3:0] e);
        wr(FRSC_WDATA_OFS, d);
        wr(FRSC_CMD_OFS, {7'h00, w, b, 5'h00, op});
        waitdone(e);
    endtask : cmdc
    initial begin
        nrst = 1'b0;
        cap_256k = 1'b0;
        irq_req = 1'b0;
        fetch_req = 1'b0;
        fetch_addr = 16'h0000;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(FRSC_SEC_OFS, v);
        chk(v, 32'h7);
        rd(8'h18, v);
        chk({31'h0, frsc_prog_model_i.rd_err}, 32'h1);
        wr(FRSC_CTRL_OFS, 32'h2);
        cmdc(FRSC_OP_BLK_ERASE, 8'h08, 9'h0, 32'h0, 4'h6);
        cmdc(FRSC_OP_CHIP_ERASE, 8'h00, 9'h0, 32'h0, 4'h6);
        cmdc(FRSC_OP_WRITE, 8'h08, 9'h0, 32'h0, 4'h6);
        cmdc(FRSC_OP_SECURE, 8'h00, 9'h0, 32'h0, 4'h2);
        wr(FRSC_CTRL_OFS, 32'h0);
        cmdc(FRSC_OP_SECURE, 8'h00, 9'h0, 32'h1, 4'h2);
        cmdc(FRSC_OP_SECURE, 8'h00, 9'h0, 32'h0, 4'h6);
        cmdc(FRSC_OP_CHIP_ERASE, 8'h00, 9'h0, 32'h0, 4'h6);
        cmdc(FRSC_OP_VERIFY, 8'h04, 9'h0, 32'h0, 4'h6);
        cmdc(FRSC_OP_BLK_ERASE, 8'h04, 9'h0, 32'h0, 4'h2);
        cmdc(FRSC_OP_WRITE, 8'h04, 9'h0, 32'hA5C30F96, 4'h2);
        cmdc(FRSC_OP_BLANK, 8'h04, 9'h0, 32'h0, 4'hA);
        wr(FRSC_CTRL_OFS, 32'h1);
        cmdc(FRSC_OP_READ, 8'h00, 9'h0, 32'h0, 4'h2);
        rd(FRSC_RDATA_OFS, v);
        chk(v, 32'hA5C30F96);
        fetch_req <= 1'b1;
        @(posedge clk);
        #1;
        chk(fetch_data, 32'hA5C30F96);
        chk({31'h0, fetch_valid}, 32'h1);
        wr(FRSC_CMD_OFS, {16'h0000, 8'h09, 5'h00, FRSC_OP_BLK_ERASE});
        irq_req <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, fetch_blocked}, 32'h1);
        chk({31'h0, irq_ack}, 32'h1);
        waitdone(4'h2);
        fetch_req <= 1'b0;
        irq_req <= 1'b0;
        wr(FRSC_CTRL_OFS, 32'h2);
        cmdc(FRSC_OP_SECURE, 8'h00, 9'h0, 32'hD, 4'h2);
        cmdc(FRSC_OP_READ, 8'h04, 9'h0, 32'h0, 4'h6);
        cmdc(FRSC_OP_CHIP_ERASE, 8'h00, 9'h0, 32'h0, 4'h2);
        rd(FRSC_SEC_OFS, v);
        chk(v, 32'h0);
        cmdc(FRSC_OP_READ, 8'h04, 9'h0, 32'h0, 4'h2);
        rd(FRSC_RDATA_OFS, v);
        chk(v, FRSC_ERASED);
        cmdc(FRSC_OP_SECURE, 8'h00, 9'h0, 32'h0310, 4'h2);
        cmdc(FRSC_OP_BLK_ERASE, 8'h02, 9'h0, 32'h0, 4'h6);
        cmdc(FRSC_OP_BLK_ERASE, 8'h08, 9'h0, 32'h0, 4'h2);
        cmdc(FRSC_OP_CHIP_ERASE, 8'h00, 9'h0, 32'h0, 4'h6);
        cmdc(FRSC_OP_SECURE, 8'h00, 9'h0, 32'h2, 4'h2);
        cmdc(FRSC_OP_WRITE, 8'h08, 9'h1, 32'h0F0F0F0F, 4'h2);
        finish_test();
    end
endmodule : frsc_top_test
`default_nettype wire
